//--- hw/rtc_calendar_backup_consts.vh
// Purpose: register map, field positions and reset values of the rtc
// Assumes: 32-bit axi4-lite data, one aligned word per register
// Notes:   definitions only
`ifndef RTC_CALENDAR_BACKUP_CONSTS_VH
`define RTC_CALENDAR_BACKUP_CONSTS_VH

`define A_TIME    8'h00
`define A_DATE    8'h04
`define A_CTRL    8'h08
`define A_PRESC   8'h0C
`define A_SUBSEC  8'h10
`define A_SHIFT   8'h14
`define A_CALIB   8'h18
`define A_WUTR    8'h1C
`define A_ALRA    8'h20
`define A_ALRB    8'h24
`define A_TSTIME  8'h28
`define A_TSDATE  8'h2C
`define A_TSSUB   8'h30
`define A_STAT    8'h34
`define A_CLR     8'h38
`define A_IEN     8'h3C
`define A_BKP     8'h40
`define A_BKP_END 8'h8C
`define BKP_N     20

`define RST_TIME  32'h00000000
`define RST_DATE  32'h00002101
`define RST_CTRL  15'h0000
`define RST_APRE  7'h7F
`define RST_SPRE  15'h00FF
`define RST_WUTR  17'h1FFFF

`define C_FMT12   0
`define C_CLKSEL  1
`define C_REFON   3
`define C_REF60   4
`define C_WUCK    5
`define C_WUTE    8
`define C_ALRAE   9
`define C_ALRBE   10
`define C_TFLT    11
`define C_TSE     13
`define C_TAMPE   14

`define S_ALRA    0
`define S_ALRB    1
`define S_WUT     2
`define S_TS      3
`define S_TAMP    4
`define N_EV      5

`define HSE_DIV_LAST 5'h1F
`define CAL_SLOT_BIT 11
`define CAL_INS_POS  11'h400
`define REF50_LAST   6'd49
`define REF60_LAST   6'd59
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2

`endif

//--- hw/rtc_calendar_backup.v
// Purpose: bcd calendar rtc with alarms, wake-up timer, tamper,
//          timestamp and backup registers behind axi4-lite
// Assumes: rtc clock pins are slow against aclk and sampled by it
// Notes:
`timescale 1ns/1ps
`include "rtc_calendar_backup_consts.vh"

module rtc_calendar_backup (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite slave
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // clock source pins
  input  wire        low_speed_crystal_clock,
  input  wire        internal_rc_slow_clock_one,
  input  wire        internal_rc_slow_clock_two,
  input  wire        high_speed_crystal_clock,
  // event and supply pins
  input  wire        ref_clock_in,
  input  wire        tamper_in,
  input  wire        timestamp_in,
  input  wire        on_battery,
  input  wire        in_shutdown,
  // events
  output wire        irq,
  output wire        wakeup_request
);

  reg  [8:0]  sync1, sync2, sync3;
  wire [8:0]  rise = sync2 & ~sync3;
  reg  [14:0] ctrl;
  reg  [6:0]  apre;
  reg  [14:0] spre;
  reg  [8:0]  calm;
  reg         calp;
  reg  [16:0] wut_rl;
  reg  [31:0] alr [0:1];
  reg  [6:0]  sec, min;
  reg  [5:0]  hour, date;
  reg         pm;
  reg  [4:0]  month;
  reg  [2:0]  wday;
  reg  [7:0]  year;
  reg  [31:0] ts_time, ts_date;
  reg  [14:0] ts_sub;
  reg  [`N_EV-1:0] status, ien;
  reg  [31:0] bkp [0:`BKP_N-1];
  localparam [31:0] date_at_reset = `RST_DATE;

  // pins pass two flops; sync3 only feeds edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
      sync3 <= 9'h000;
    end else begin
      sync1 <= {in_shutdown, on_battery, timestamp_in, tamper_in,
                ref_clock_in, high_speed_crystal_clock,
                internal_rc_slow_clock_two, internal_rc_slow_clock_one,
                low_speed_crystal_clock};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // clock selection and divide
  reg  [4:0] hse_cnt;
  reg        src_tick;
  wire [1:0] clksel = ctrl[`C_CLKSEL+1:`C_CLKSEL];
  wire rc_stop = (clksel == 2'h1 || clksel == 2'h2) &&
                 (sync2[7] || sync2[8]);
  wire rtc_tick = src_tick && !rc_stop;
  always @* begin
    case (clksel)
      2'h0:    src_tick = rise[0];
      2'h1:    src_tick = rise[1];
      2'h2:    src_tick = rise[2];
      default: src_tick = rise[3] && hse_cnt == `HSE_DIV_LAST;
    endcase
  end

  // smooth calibration: 512 slots per 2^20 pulses, mask or insert
  reg  [19:0] cal_cnt;
  reg  [14:0] shift_left;
  reg         add1s;
  wire slot0 = cal_cnt[`CAL_SLOT_BIT-1:0] == 11'h000;
  wire mask_cal = slot0 && cal_cnt[19:`CAL_SLOT_BIT] < calm;
  wire ins_cal = calp &&
                 cal_cnt[`CAL_SLOT_BIT-1:0] == `CAL_INS_POS;
  wire mask_shf = shift_left != 15'h0000 && !mask_cal;
  wire [1:0] inc = !rtc_tick ? 2'h0 :
                   (mask_cal || mask_shf) ? 2'h0 :
                   ins_cal ? 2'h2 : 2'h1;
  reg  [6:0]  apre_cnt;
  reg  [14:0] sub_cnt;
  wire [7:0] asum = {1'b0, apre_cnt} + {6'h00, inc};
  wire ck_apre = asum > {1'b0, apre};
  reg  [5:0]  ref_cnt;
  wire refon = ctrl[`C_REFON];
  wire [5:0] ref_last = ctrl[`C_REF60] ? `REF60_LAST : `REF50_LAST;
  wire sec_ref = refon && rise[4] && ref_cnt == ref_last;
  wire sec_pre = !refon && ck_apre && sub_cnt == 15'h0000;
  wire sec_tick = sec_ref || sec_pre || add1s;
  reg  sec_tick_d;

  // calendar carries
  wire fmt12 = ctrl[`C_FMT12];
  wire sec_wrap = sec == 7'h59;
  wire min_wrap = min == 7'h59;
  wire hour_wrap = fmt12 ? (pm && hour == 6'h11) : hour == 6'h23;
  wire leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6) :
              (year[3:0] == 4'h0 || year[3:0] == 4'h4 ||
               year[3:0] == 4'h8);
  wire [5:0] last_day = (month == 5'h02) ? (leap ? 6'h29 : 6'h28) :
                        (month == 5'h04 || month == 5'h06 ||
                         month == 5'h09 || month == 5'h11) ? 6'h30 :
                        6'h31;
  wire tick_min = sec_tick && sec_wrap;
  wire tick_hour = tick_min && min_wrap;
  wire tick_day = tick_hour && hour_wrap;
  wire tick_mon = tick_day && date == last_day;
  wire tick_year = tick_mon && month == 5'h12;

  function [7:0] binc;
    input [7:0] v;
    begin
      binc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} :
             {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  wire [7:0] sec_n = binc({1'b0, sec});
  wire [7:0] min_n = binc({1'b0, min});
  wire [7:0] hour_n = binc({2'h0, hour});
  wire [7:0] date_n = binc({2'h0, date});
  wire [7:0] mon_n = binc({3'h0, month});
  wire [7:0] year_n = binc(year);

  // wake-up timer clock: rtc clock over 2..16 or the second tick
  reg  [3:0]  wdiv;
  reg  [16:0] wut_cnt;
  wire [2:0] wsel = ctrl[`C_WUCK+2:`C_WUCK];
  wire [3:0] wmask = 4'hF >> (2'h3 - wsel[1:0]);
  wire wut_tick = wsel[2] ? sec_tick :
                  rtc_tick && (&(wdiv | ~wmask));
  wire wut_evt = ctrl[`C_WUTE] && wut_tick && wut_cnt == 17'h00000;

  // tamper filter: edge, or 2, 4, 8 equal samples at rtc rate
  // count saturates past eight so a held pin fires only once
  reg  [3:0] tf_cnt;
  wire [1:0] tflt = ctrl[`C_TFLT+1:`C_TFLT];
  wire tf_hit = rtc_tick && sync2[5] &&
                (tf_cnt + 4'h1) == (4'h1 << tflt);
  wire tamp_evt = ctrl[`C_TAMPE] &&
                  (tflt == 2'h0 ? rise[5] : tf_hit);
  wire ts_evt = ctrl[`C_TSE] &&
                (rise[6] || tamp_evt || rise[7]);

  // alarms: each field can be masked out of the compare
  wire [1:0] alr_hit;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_alr
      wire [31:0] a = alr[gi];
      assign alr_hit[gi] = ctrl[`C_ALRAE+gi] && sec_tick_d &&
        (a[7] || a[6:0] == sec) && (a[15] || a[14:8] == min) &&
        (a[23] || (a[21:16] == hour && a[22] == pm)) &&
        (a[31] || a[29:24] == date);
    end
  endgenerate

  wire [`N_EV-1:0] ev;
  assign ev[`S_ALRA] = alr_hit[0];
  assign ev[`S_ALRB] = alr_hit[1];
  assign ev[`S_WUT] = wut_evt;
  assign ev[`S_TS] = ts_evt;
  assign ev[`S_TAMP] = tamp_evt;
  assign irq = |(status & ien);
  assign wakeup_request = irq;

  // axi4-lite slave: address and data taken in either order
  reg        aw_got, w_got;
  reg [7:0]  waddr;
  reg [31:0] wdat;
  reg [3:0]  wstb;
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_got && w_got;

  function mapped;
    input [7:0] a;
    begin
      mapped = a[1:0] == 2'h0 && a <= `A_BKP_END;
    end
  endfunction

  function [31:0] regval;
    input [7:0] a;
    reg   [7:0] bi;
    begin
      bi = (a - `A_BKP) >> 2;
      if (a == `A_TIME)
        regval = {9'h000, pm, hour, 1'b0, min, 1'b0, sec};
      else if (a == `A_DATE)
        regval = {8'h00, year, wday, month, 2'h0, date};
      else if (a == `A_CTRL)
        regval = {17'h00000, ctrl};
      else if (a == `A_PRESC)
        regval = {9'h000, apre, 1'b0, spre};
      else if (a == `A_SUBSEC)
        regval = {17'h00000, sub_cnt};
      else if (a == `A_CALIB)
        regval = {16'h0000, calp, 6'h00, calm};
      else if (a == `A_WUTR)
        regval = {15'h0000, wut_rl};
      else if (a == `A_ALRA)
        regval = alr[0];
      else if (a == `A_ALRB)
        regval = alr[1];
      else if (a == `A_TSTIME)
        regval = ts_time;
      else if (a == `A_TSDATE)
        regval = ts_date;
      else if (a == `A_TSSUB)
        regval = {17'h00000, ts_sub};
      else if (a == `A_STAT)
        regval = {27'h0000000, status};
      else if (a == `A_IEN)
        regval = {27'h0000000, ien};
      else if (a >= `A_BKP && a <= `A_BKP_END)
        regval = bkp[bi[4:0]];
      else
        regval = 32'h00000000;
    end
  endfunction

  wire [31:0] bm = {{8{wstb[3]}}, {8{wstb[2]}}, {8{wstb[1]}},
                    {8{wstb[0]}}};
  wire [31:0] wval = (regval(waddr) & ~bm) | (wdat & bm);
  wire wr_ok = do_wr && mapped(waddr);
  wire [7:0] bidx = (waddr - `A_BKP) >> 2;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 8'h00;
      wdat <= 32'h00000000;
      wstb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        waddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdat <= s_axi_wdata;
        wstb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(waddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= regval(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // backup words take no reset at all, so no reset can clear them
  always @(posedge aclk) begin
    if (wr_ok && waddr >= `A_BKP)
      bkp[bidx[4:0]] <= wval;
  end

  // time base, calendar, timers and flags
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `RST_CTRL;
      apre <= `RST_APRE;
      spre <= `RST_SPRE;
      calm <= 9'h000;
      calp <= 1'b0;
      wut_rl <= `RST_WUTR;
      alr[0] <= 32'h00000000;
      alr[1] <= 32'h00000000;
      {pm, hour, min, sec} <= 21'h000000;
      {year, wday, month, date} <= {date_at_reset[23:8], date_at_reset[5:0]};
      hse_cnt <= 5'h00;
      cal_cnt <= 20'h00000;
      shift_left <= 15'h0000;
      add1s <= 1'b0;
      apre_cnt <= 7'h00;
      sub_cnt <= `RST_SPRE;
      ref_cnt <= 6'h00;
      sec_tick_d <= 1'b0;
      wdiv <= 4'h0;
      wut_cnt <= `RST_WUTR;
      tf_cnt <= 4'h0;
      ts_time <= 32'h00000000;
      ts_date <= 32'h00000000;
      ts_sub <= 15'h0000;
      status <= {`N_EV{1'b0}};
      ien <= {`N_EV{1'b0}};
    end else begin
      sec_tick_d <= sec_tick;
      add1s <= 1'b0;
      if (rise[3])
        hse_cnt <= hse_cnt + 5'h01;
      if (rtc_tick) begin
        cal_cnt <= cal_cnt + 20'h00001;
        wdiv <= wdiv + 4'h1;
        tf_cnt <= !sync2[5] ? 4'h0 :
                  (tf_cnt == 4'hF ? tf_cnt : tf_cnt + 4'h1);
        if (mask_shf)
          shift_left <= shift_left - 15'h0001;
      end
      apre_cnt <= ck_apre ? asum[6:0] - apre - 7'h01 : asum[6:0];
      if (sec_ref || (ck_apre && sub_cnt == 15'h0000))
        sub_cnt <= spre;
      else if (ck_apre)
        sub_cnt <= sub_cnt - 15'h0001;
      if (refon && rise[4])
        ref_cnt <= sec_ref ? 6'h00 : ref_cnt + 6'h01;
      if (sec_tick) begin
        sec <= sec_wrap ? 7'h00 : sec_n[6:0];
        if (tick_min)
          min <= min_wrap ? 7'h00 : min_n[6:0];
        if (tick_hour) begin
          if (fmt12) begin
            hour <= hour == 6'h12 ? 6'h01 : hour_n[5:0];
            if (hour == 6'h11)
              pm <= !pm;
          end else begin
            hour <= hour_wrap ? 6'h00 : hour_n[5:0];
          end
        end
        if (tick_day) begin
          wday <= wday == 3'h7 ? 3'h1 : wday + 3'h1;
          date <= tick_mon ? 6'h01 : date_n[5:0];
        end
        if (tick_mon)
          month <= tick_year ? 5'h01 : mon_n[4:0];
        if (tick_year)
          year <= year_n;
      end
      if (!ctrl[`C_WUTE])
        wut_cnt <= wut_rl;
      else if (wut_tick)
        wut_cnt <= wut_cnt == 17'h00000 ? wut_rl :
                   wut_cnt - 17'h00001;
      if (ts_evt) begin
        ts_time <= {9'h000, pm, hour, 1'b0, min, 1'b0, sec};
        ts_date <= {8'h00, year, wday, month, 2'h0, date};
        ts_sub <= sub_cnt;
      end
      // an event in the clearing cycle keeps its flag
      status <= (status & ~((wr_ok && waddr == `A_CLR) ?
                wdat[`N_EV-1:0] : {`N_EV{1'b0}})) | ev;
      if (wr_ok) begin
        if (waddr == `A_TIME) begin
          {pm, hour} <= wval[22:16];
          min <= wval[14:8];
          sec <= wval[6:0];
          apre_cnt <= 7'h00;
          sub_cnt <= spre;
        end else if (waddr == `A_DATE) begin
          year <= wval[23:16];
          wday <= wval[15:13];
          month <= wval[12:8];
          date <= wval[5:0];
        end else if (waddr == `A_CTRL) begin
          ctrl <= wval[14:0];
        end else if (waddr == `A_PRESC) begin
          apre <= wval[22:16];
          spre <= wval[14:0];
        end else if (waddr == `A_SHIFT) begin
          shift_left <= wdat[14:0];
          add1s <= wdat[31];
        end else if (waddr == `A_CALIB) begin
          calp <= wval[15];
          calm <= wval[8:0];
        end else if (waddr == `A_WUTR) begin
          wut_rl <= wval[16:0];
        end else if (waddr == `A_ALRA) begin
          alr[0] <= wval;
        end else if (waddr == `A_ALRB) begin
          alr[1] <= wval;
        end else if (waddr == `A_IEN) begin
          ien <= wval[`N_EV-1:0];
        end
      end
    end
  end

endmodule // rtc_calendar_backup

//--- tb/rtc_calendar_backup_checker.sv
// Purpose: bus and interrupt checks on the rtc top ports
// Assumes: one aclk domain, synchronous active-low reset
// Notes:   attached by bind at the foot of this file
`timescale 1ns/1ps
module rtc_calendar_backup_checker (
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // events
  input wire        irq,
  input wire        wakeup_request
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw_go  = s_axi_awvalid && s_axi_awready &&
                s_axi_wvalid && s_axi_wready;
  wire ar_go  = s_axi_arvalid && s_axi_arready;
  wire aw_bad = s_axi_awaddr > 8'h8C || s_axi_awaddr[1:0] != 2'h0;
  wire ar_bad = s_axi_araddr > 8'h8C || s_axi_araddr[1:0] != 2'h0;
  // both halves are latched first, the response follows one edge later
  property p_b_bad;
    aw_go && aw_bad |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h2;
  endproperty
  a_b_bad: assert property (p_b_bad)
    else $error("unmapped write not refused");
  property p_b_ok;
    aw_go && !aw_bad |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0;
  endproperty
  a_b_ok: assert property (p_b_ok)
    else $error("mapped write not answered");
  property p_r_bad;
    ar_go && ar_bad |=>
      s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_r_bad: assert property (p_r_bad)
    else $error("unmapped read not refused");
  property p_r_ok;
    ar_go && !ar_bad |=> s_axi_rvalid && s_axi_rresp == 2'h0;
  endproperty
  a_r_ok: assert property (p_r_ok)
    else $error("mapped read not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && !s_axi_arready && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_stall;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_stall: assert property (p_stall)
    else $error("write taken during response");
  property p_irq;
    irq == wakeup_request;
  endproperty
  a_irq: assert property (p_irq)
    else $error("wake request differs from irq");
endmodule // rtc_calendar_backup_checker

bind rtc_calendar_backup rtc_calendar_backup_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .irq(irq), .wakeup_request(wakeup_request));

//--- tb/tb_rtc_calendar_backup.sv
// Purpose: self-checking bench for the rtc block
// Assumes: prescaler 0 gives one second per rtc clock edge
// Notes:   rtc pins toggle every 4 aclk cycles, well under aclk/2
`timescale 1ns/1ps
`include "rtc_calendar_backup_consts.vh"
module tb_rtc_calendar_backup;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr, araddr;
  reg         awvalid, wvalid, bready, arvalid, rready;
  reg  [31:0] wdata, got;
  reg  [3:0]  wstrb;
  reg  [1:0]  rsp;
  reg  [8:0]  pins;
  reg  [31:0] ti [0:5], di [0:5], te [0:5], de [0:5];
  wire        awready, wready, bvalid, arready, rvalid, irq, wake;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     fail_count, samples_checked;

  rtc_calendar_backup dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .low_speed_crystal_clock(pins[0]),
    .internal_rc_slow_clock_one(pins[1]), .internal_rc_slow_clock_two(pins[2]),
    .high_speed_crystal_clock(pins[3]), .ref_clock_in(pins[4]),
    .tamper_in(pins[5]), .timestamp_in(pins[6]), .on_battery(pins[7]),
    .in_shutdown(pins[8]), .irq(irq), .wakeup_request(wake));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task chk(input string what, input [31:0] exp, input [31:0] seen);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task rst;
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // address and data offered together, each dropped once taken
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      n = n + 1;
    end while (bvalid !== 1'b1 && n < 64);
    rsp = bresp;
    bready <= 1'b0;
    if (n == 64) chk("write answer", 1, 0);
  endtask

  task rd(input [7:0] a);
    integer n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    n = 0;
    // ready raised late so the data must stand one cycle
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) rready <= 1'b1;
      n = n + 1;
    end while (!(rvalid === 1'b1 && rready === 1'b1) && n < 64);
    got = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (n == 64) chk("read answer", 1, 0);
  endtask

  task rc(input [7:0] a, input [31:0] e, input string what);
    rd(a);
    chk(what, e, got);
  endtask

  task pulse(input integer p, input integer n);
    repeat (n) begin
      pins[p] <= 1'b1;
      repeat (4) @(posedge aclk);
      pins[p] <= 1'b0;
      repeat (4) @(posedge aclk);
    end
  endtask

  task t_reset;
    rc(`A_TIME, `RST_TIME, "time");
    rc(`A_DATE, `RST_DATE, "date");
    rc(`A_PRESC, 32'h007F00FF, "prescaler");
    rc(`A_WUTR, 32'h0001FFFF, "wake reload");
    rc(`A_STAT, 32'h0, "status");
    $display("test reset done");
  endtask

  task t_backup;
    integer i;
    for (i = 0; i < `BKP_N; i = i + 1)
      wr(8'(`A_BKP + 4 * i), {8'hC3, i[23:0]});
    wr(8'h90, 32'h0);
    chk("unmapped bresp", `RESP_SLVERR, rsp);
    rst;
    for (i = 0; i < `BKP_N; i = i + 1)
      rc(8'(`A_BKP + 4 * i), {8'hC3, i[23:0]}, "backup word");
    rc(8'h90, 32'h0, "unmapped rdata");
    chk("unmapped rresp", `RESP_SLVERR, rsp);
    $display("test backup done");
  endtask

  // bs is {shutdown, battery}
  task src(input [31:0] ctl, input integer p, input integer n,
           input [1:0] bs, input [3:0] e);
    reg [31:0] t0;
    wr(`A_CTRL, ctl);
    pins[8:7] <= bs;
    rd(`A_TIME);
    t0 = got;
    pulse(p, n);
    pins[8:7] <= 2'b00;
    rc(`A_TIME, t0 + e, "seconds from source");
  endtask

  task t_clk;
    wr(`A_PRESC, 32'h0);
    wr(`A_TIME, 32'h0);
    src(32'h8, 4, 49, 2'b00, 0);
    src(32'h8, 4, 1, 2'b00, 1);
    src(32'h18, 4, 59, 2'b00, 0);
    src(32'h18, 4, 1, 2'b00, 1);
    src(32'h2, 1, 1, 2'b01, 0);
    src(32'h2, 1, 1, 2'b10, 0);
    src(32'h2, 1, 1, 2'b00, 1);
    src(32'h4, 2, 1, 2'b01, 0);
    src(32'h4, 2, 1, 2'b00, 1);
    src(32'h0, 0, 1, 2'b01, 1);
    src(32'h6, 3, 31, 2'b00, 0);
    src(32'h6, 3, 1, 2'b00, 1);
    $display("test clock sources done");
  endtask

  task t_shift;
    wr(`A_CTRL, 32'h0);
    wr(`A_TIME, 32'h0);
    wr(`A_SHIFT, 32'h80000000);
    rc(`A_TIME, 32'h1, "add one second");
    wr(`A_SHIFT, 32'h1);
    pulse(0, 2);
    rc(`A_TIME, 32'h2, "one pulse dropped");
    $display("test shift done");
  endtask

  task t_roll;
    integer i;
    ti = '{32'h00235959, 32'h00235959, 32'h00235959, 32'h00235959,
           32'h00235959, 32'h00115959};
    di = '{32'h00232228, 32'h00242228, 32'h0024E229, 32'h00236430,
           32'h0023B231, 32'h00232228};
    te = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h00520000};
    de = '{32'h00234301, 32'h00244229, 32'h00242301, 32'h00238501,
           32'h0024C101, 32'h00232228};
    for (i = 0; i < 6; i = i + 1) begin
      wr(`A_CTRL, (i == 5) ? 32'h1 : 32'h0);
      wr(`A_TIME, ti[i]);
      wr(`A_DATE, di[i]);
      pulse(0, 1);
      rc(`A_TIME, te[i], "rolled time");
      rc(`A_DATE, de[i], "rolled date");
    end
    $display("test rollover done");
  endtask

  task ev(input [31:0] ctl, input integer p, input [31:0] e);
    wr(`A_CTRL, ctl);
    pulse(p, 1);
    rc(`A_STAT, e, "event status");
    chk("irq raised", e != 0, irq);
    if (e != 0) rc(`A_TSTIME, 32'h00123456, "stamped time");
    wr(`A_CLR, 32'h1F);
    rc(`A_STAT, 32'h0, "status cleared");
    chk("irq cleared", 0, irq);
  endtask

  task t_event;
    wr(`A_IEN, 32'h18);
    wr(`A_TIME, 32'h00123456);
    ev(32'h6000, 5, 32'h18);
    ev(32'h2000, 6, 32'h08);
    ev(32'h2000, 7, 32'h08);
    // filter samples at rtc rate, so no rtc edge means no tamper
    ev(32'h7800, 5, 32'h00);
    wr(`A_CTRL, 32'h4800);
    pins[5] <= 1'b1;
    pulse(0, 2);
    pins[5] <= 1'b0;
    rc(`A_STAT, 32'h10, "filtered tamper");
    wr(`A_CLR, 32'h1F);
    $display("test events done");
  endtask

  task t_wake;
    wr(`A_IEN, 32'h0);
    wr(`A_ALRA, 32'h80808005);
    wr(`A_ALRB, 32'h80808006);
    wr(`A_CTRL, 32'h600);
    wr(`A_TIME, 32'h4);
    pulse(0, 2);
    rc(`A_STAT, 32'h3, "alarms");
    wr(`A_CLR, 32'h3);
    wr(`A_WUTR, 32'h3);
    wr(`A_CTRL, 32'h100);
    pulse(0, 5);
    rc(`A_STAT, 32'h0, "wake early");
    pulse(0, 5);
    rc(`A_STAT, 32'h4, "wake due");
    chk("irq masked", 0, irq);
    wr(`A_IEN, 32'h4);
    chk("irq enabled", 1, irq);
    chk("wake request", 1, wake);
    wr(`A_CTRL, 32'h0);
    wr(`A_CLR, 32'h4);
    rc(`A_STAT, 32'h0, "wake cleared");
    chk("irq off", 0, irq);
    $display("test wake-up timer done");
  endtask

  initial begin
    fail_count = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, pins} = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    wstrb = 4'hF;
    rst;
    t_reset;
    t_backup;
    t_clk;
    t_shift;
    t_roll;
    t_event;
    t_wake;
    summarize;
  end

  // the whole run needs well under 10000 cycles
  initial begin
    repeat (60000) @(posedge aclk);
    fail_count = fail_count + 1;
    summarize;
  end
endmodule // tb_rtc_calendar_backup
